/* File: rtl/system_reset_clock_sequencer.sv */
// Reset, clock start-up and watchdog sequencer
`timescale 1ns/100ps
`default_nettype none

module system_reset_clock_sequencer
   import reset_seq_pkg::*;
#(
   parameter int LONG_CYC = LONG_DELAY
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        por_i,
   input  wire logic        low_voltage_i,
   input  wire logic        bad_opcode_i,
   input  wire logic        stop_exec_i,
   input  wire logic        wait_exec_i,
   input  wire logic        opcode_fetch_i,
   input  wire logic        unmapped_i,
   input  wire logic [15:0] cpu_addr_i,
   input  wire logic        cpu_write_i,
   input  wire logic        wake_i,
   input  wire logic        monitor_mode_i,
   input  wire logic        break_i,
   input  wire logic        reset_pin_i,
   output logic             reset_pin_o,
   output logic             reset_pin_oe_o,
   output logic             gpio_in_o,
   output logic             internal_reset_o,
   output logic             cpu_reset_o,
   output logic [15:0]      reset_vector_o,
   output logic             osc_enable_o,
   output logic             cpu_clk_en_o,
   output logic             periph_clk_en_o,
   output logic             osc_clk_x2_o,
   output logic             bus_clk_o,
   output logic             watchdog_tick_o,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o
);

   typedef struct packed {
      seq_state_type         st;
      logic [CNT_WIDTH-1:0]  cnt;
      logic [12:0]           phase;
      logic [WDOG_WIDTH-1:0] wdog;
      logic [NCAUSE-1:0]     cause;
      logic [4:0]            cfg;
      logic                  waiting;
      logic [7:0]            pin_low;
      logic [1:0]            div;
      logic                  ack;
      logic [31:0]           rdata;
   } state_type;

   state_type s_q, s_d;

   logic                  pin_en;
   logic                  pin_drive;
   logic                  pin_req;
   logic                  wd_overflow;
   logic                  stop_illegal;
   logic                  addr_reset;
   logic                  service;
   logic                  wd_run;
   logic                  long_src;
   logic                  int_req;
   logic                  wb_req;
   logic [NCAUSE-1:0]     new_cause;
   logic [CNT_WIDTH-1:0]  recov_len;

   always_comb begin
      pin_en       = s_q.cfg[CFG_RESET_PIN_ENABLE_BIT];
      // Own drive of the pin is not an outside reset
      pin_drive    = pin_en & ((s_q.st == ST_LONG) | (s_q.st == ST_PIN_DRIVE));
      stop_illegal = stop_exec_i & ~s_q.cfg[CFG_STOPEN_BIT];
      addr_reset   = opcode_fetch_i & unmapped_i;
      service      = cpu_write_i & (cpu_addr_i == SERVICE_ADDR) & (s_q.st == ST_RUN);
      wd_run       = s_q.cfg[CFG_WDEN_BIT] &
                     ~(break_i & monitor_mode_i & s_q.cfg[CFG_BREAK_WATCHDOG_DISABLE_BIT]);
      wd_overflow  = wd_run & (&s_q.wdog) & s_q.cnt[CNT_WIDTH-1];
      pin_req      = pin_en & ~reset_pin_i & ~pin_drive;
      long_src     = por_i | low_voltage_i;
      int_req      = long_src | wd_overflow | bad_opcode_i | stop_illegal | addr_reset;
      new_cause    = '0;
      new_cause[C_POR]  = por_i;
      new_cause[C_LV]   = low_voltage_i;
      new_cause[C_WDOG] = wd_overflow;
      new_cause[C_OP]   = bad_opcode_i | stop_illegal;
      new_cause[C_AD]   = addr_reset;
      new_cause[C_PIN]  = pin_req & (s_q.pin_low == 8'(MIN_PIN_LOW_CYC - 1));
      recov_len    = s_q.cfg[CFG_SHORT_STOP_RECOVERY_BIT] ? CNT_WIDTH'(SHORT_DELAY - 1)
                                            : CNT_WIDTH'(LONG_CYC - 1);
      wb_req       = wb_cyc_i & wb_stb_i & ~s_q.ack;
   end

   always_comb begin
      s_d       = s_q;
      s_d.ack   = wb_req;
      s_d.div   = s_q.div + 2'h1;
      s_d.phase = s_q.phase + 13'h1;
      s_d.cause = s_q.cause | new_cause;

      // Prescale counter: 13th stage clears the counter and ticks the watchdog
      if (s_q.cnt[CNT_WIDTH-1]) begin
         s_d.cnt = '0;
      end else begin
         s_d.cnt = s_q.cnt + CNT_WIDTH'(1);
      end
      if (service) begin
         s_d.cnt[SERVICE_HI_BIT:SERVICE_LO_BIT] = '0;
         s_d.wdog = '0;
      end else if (wd_run & s_q.cnt[CNT_WIDTH-1]) begin
         s_d.wdog = s_q.wdog + WDOG_WIDTH'(1);
      end

      s_d.pin_low = pin_req ? ((s_q.pin_low == 8'hff) ? s_q.pin_low : s_q.pin_low + 8'h1) : 8'h0;

      if (wait_exec_i & (s_q.st == ST_RUN)) begin
         s_d.waiting = 1'b1;
      end
      if (wake_i) begin
         s_d.waiting = 1'b0;
      end

      unique case (s_q.st)
         ST_RUN: begin
            if (stop_exec_i & ~stop_illegal) begin
               s_d.st  = ST_STOP;
               s_d.cnt = '0;
            end
         end
         ST_STOP: begin
            if (wake_i | pin_req) begin
               s_d.st    = ST_RECOVER;
               s_d.phase = '0;
            end
         end
         ST_RECOVER: begin
            if (s_q.phase == recov_len) begin
               s_d.st      = ST_RUN;
               s_d.waiting = 1'b0;
            end
         end
         ST_LONG: begin
            if (long_src) begin
               s_d.phase = '0;
            end else if (s_q.phase == 13'(LONG_CYC - 1)) begin
               s_d.st    = ST_PIN_DRIVE;
               s_d.phase = '0;
            end
         end
         ST_PIN_DRIVE: begin
            if (s_q.phase == 13'(PIN_DRIVE_CYC - 1)) begin
               s_d.st    = ST_INTERNAL_RESET_HOLD;
               s_d.phase = '0;
            end
         end
         ST_INTERNAL_RESET_HOLD: begin
            if (s_q.phase == 13'(INTERNAL_RESET_EXTRA_CYC - 1)) begin
               s_d.st = ST_RUN;
            end
         end
         default: s_d.st = ST_RUN;
      endcase

      // Every internal source restarts the release sequence
      if (int_req) begin
         s_d.st      = long_src ? ST_LONG : ST_PIN_DRIVE;
         s_d.phase   = '0;
         s_d.cnt     = '0;
         s_d.wdog    = '0;
         s_d.waiting = 1'b0;
      end else if (pin_req & (s_q.st != ST_STOP)) begin
         s_d.st      = ST_INTERNAL_RESET_HOLD;
         s_d.phase   = '0;
         s_d.waiting = 1'b0;
      end
      // Register bus
      s_d.rdata = '0;
      if (wb_req & wb_we_i & wb_sel_i[0]) begin
         if (wb_adr_i == ADDR_CFG) begin
            s_d.cfg = wb_dat_i[4:0];
         end else if (wb_adr_i == ADDR_CAUSE) begin
            s_d.cause = (s_q.cause & ~wb_dat_i[NCAUSE-1:0]) | new_cause;
         end
      end
      if (wb_req & ~wb_we_i) begin
         if (wb_adr_i == ADDR_CFG) begin
            s_d.rdata = {27'h0, s_q.cfg};
         end else if (wb_adr_i == ADDR_CAUSE) begin
            s_d.rdata = {26'h0, s_q.cause};
         end else if (wb_adr_i == ADDR_STATUS) begin
            s_d.rdata = {15'h0, reset_pin_i, 3'h0, s_q.cnt};
         end
      end
      // Power-on wins over a bus write
      if (por_i) begin
         s_d.cfg = CFG_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q       <= '0;
         s_q.st    <= ST_LONG;
         s_q.cfg   <= CFG_RESET;
         s_q.cause <= NCAUSE'(1 << C_POR);
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      reset_pin_oe_o   = pin_en & ((s_q.st == ST_LONG) | (s_q.st == ST_PIN_DRIVE));
      reset_pin_o      = 1'b0;
      gpio_in_o        = reset_pin_i & ~pin_en;
      internal_reset_o = (s_q.st == ST_LONG) | (s_q.st == ST_PIN_DRIVE) |
                         (s_q.st == ST_INTERNAL_RESET_HOLD) | pin_req;
      cpu_reset_o      = internal_reset_o;
      reset_vector_o   = monitor_mode_i ? MON_VECTOR : RESET_VECTOR;
      osc_enable_o     = 1'b1;
      periph_clk_en_o  = (s_q.st == ST_RUN) | (s_q.st == ST_PIN_DRIVE) |
                         (s_q.st == ST_INTERNAL_RESET_HOLD);
      cpu_clk_en_o     = periph_clk_en_o & ~s_q.waiting;
      osc_clk_x2_o     = s_q.div[0];
      bus_clk_o        = s_q.div[1];
      watchdog_tick_o  = s_q.cnt[CNT_WIDTH-1];
      wb_ack_o         = s_q.ack;
      wb_dat_o         = s_q.rdata;
   end

endmodule

`default_nettype wire

/* File: rtl/reset_seq_pkg.sv */
// Constants for the reset and clock start-up sequencer
package reset_seq_pkg;
   localparam int          CNT_WIDTH       = 13;
   localparam int          WDOG_WIDTH      = 6;
   localparam int          LONG_DELAY      = 4096;
   localparam int          SHORT_DELAY     = 32;
   localparam int          PIN_DRIVE_CYC   = 32;
   localparam int          INTERNAL_RESET_EXTRA_CYC  = 32;
   localparam int          RELEASE_CYC     = 64;
   localparam int          SERVICE_LO_BIT  = 5;
   localparam int          SERVICE_HI_BIT  = 12;
   localparam int          MIN_PIN_LOW_NS  = 100;
   localparam int          CLK_PERIOD_PS   = 4000;
   localparam int          MIN_PIN_LOW_CYC = (MIN_PIN_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [15:0] RESET_VECTOR    = 16'hfffe;
   localparam logic [15:0] MON_VECTOR      = 16'hfefe;
   localparam logic [15:0] SERVICE_ADDR    = 16'hffff;
   localparam logic [31:0] ADDR_CFG        = 32'h0000_0000;
   localparam logic [31:0] ADDR_CAUSE      = 32'h0000_0004;
   localparam logic [31:0] ADDR_STATUS     = 32'h0000_0008;
   localparam int          CFG_SHORT_STOP_RECOVERY_BIT   = 0;
   localparam int          CFG_RESET_PIN_ENABLE_BIT   = 1;
   localparam int          CFG_STOPEN_BIT  = 2;
   localparam int          CFG_BREAK_WATCHDOG_DISABLE_BIT   = 3;
   localparam int          CFG_WDEN_BIT    = 4;
   localparam logic [4:0]  CFG_RESET       = 5'h14;
   // Reset-cause bit positions
   localparam int          C_POR  = 0;
   localparam int          C_PIN  = 1;
   localparam int          C_WDOG = 2;
   localparam int          C_OP   = 3;
   localparam int          C_AD   = 4;
   localparam int          C_LV   = 5;
   localparam int          NCAUSE = 6;

   typedef enum logic [2:0] {
      ST_RUN       = 3'b000,
      ST_LONG      = 3'b001,
      ST_PIN_DRIVE = 3'b011,
      ST_INTERNAL_RESET_HOLD = 3'b010,
      ST_STOP      = 3'b110,
      ST_RECOVER   = 3'b111
   } seq_state_type;
endpackage

/* File: verification/reset_line_model.sv */
// External reset line with pull-up and an outside chip pulling it
`timescale 1ns/100ps
`default_nettype none
module reset_line_model (
   input  wire logic oe_i,
   input  wire logic ext_low_i,
   output logic      pin_o
);
   // Pull-up wins unless a party drives low
   assign pin_o = (oe_i || ext_low_i) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verification/system_reset_clock_sequencer_properties.sv */
// Port checker for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module seq_checker
   import reset_seq_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        por_i,
   input wire logic        bad_opcode_i,
   input wire logic        opcode_fetch_i,
   input wire logic        unmapped_i,
   input wire logic        monitor_mode_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        reset_pin_oe_o,
   input wire logic        internal_reset_o,
   input wire logic        cpu_clk_en_o,
   input wire logic        osc_clk_x2_o,
   input wire logic        bus_clk_o,
   input wire logic [15:0] reset_vector_o
);
   logic rst_q;
   always_ff @(posedge clk_i) rst_q <= rst_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_vector_pick: assert property (reset_vector_o == (monitor_mode_i ? MON_VECTOR : RESET_VECTOR)) else $error("bad vector");
   chk_half_rate: assert property (disable iff (rst_i || rst_q) osc_clk_x2_o != $past(osc_clk_x2_o)) else $error("x2 stuck");
   chk_bus_quarter: assert property ($rose(bus_clk_o) |=> bus_clk_o ##1 !bus_clk_o) else $error("bus clock rate");
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   chk_fetch_reset: assert property (opcode_fetch_i && unmapped_i |=> internal_reset_o) else $error("no fetch reset");
   chk_opcode_reset: assert property (bad_opcode_i |=> internal_reset_o) else $error("no opcode reset");
   chk_por_hold: assert property (por_i |=> internal_reset_o && !cpu_clk_en_o) else $error("por clocks");
   chk_pin_in_reset: assert property (reset_pin_oe_o |-> internal_reset_o) else $error("pin without reset");
   chk_reset_tail: assert property ($fell(reset_pin_oe_o) |-> internal_reset_o [*8]) else $error("short hold");
   cover property (opcode_fetch_i && unmapped_i);
   cover property ($fell(internal_reset_o));
   cover property (wb_ack_o);
endmodule
bind system_reset_clock_sequencer seq_checker chk (.*);
`default_nettype wire

/* File: verification/test_system_reset_clock_sequencer.sv */
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module test_system_reset_clock_sequencer;
   import reset_seq_pkg::*;
   localparam int LC = 64;
   logic clk_i = 0, rst_i = 1, por_i = 0, low_voltage_i = 0, bad_opcode_i = 0, stop_exec_i = 0, ext_low = 0;
   logic wait_exec_i = 0, opcode_fetch_i = 0, unmapped_i = 0, cpu_write_i = 0, wake_i = 0, pin;
   logic monitor_mode_i = 0, break_i = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, reset_pin_o;
   logic reset_pin_oe_o, gpio_in_o, internal_reset_o, cpu_reset_o, osc_enable_o, wb_ack_o;
   logic cpu_clk_en_o, periph_clk_en_o, osc_clk_x2_o, bus_clk_o, watchdog_tick_o;
   logic [15:0] cpu_addr_i = 16'h0000, reset_vector_o;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
   int fails = 0, cmp_count = 0, n;
   int lens[7] = '{LC + 64, 64, 64, 64, 64, LC + 64, 0};
   logic [31:0] causes[7] = '{32'h01, 32'h08, 32'h08, 32'h10, 32'h18, 32'h20, 32'h00};
   always #2 clk_i = ~clk_i;
   system_reset_clock_sequencer #(.LONG_CYC(LC)) DUT (.*, .wb_sel_i(4'hf), .reset_pin_i(pin));
   reset_line_model line (.oe_i(reset_pin_oe_o), .ext_low_i(ext_low), .pin_o(pin));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      k = 0;
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50) check(32'h0, 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic settle;
      n = 0;
      while (internal_reset_o === 1'b1 && n < 9000) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic run_reset(input int k);
      wb(1, ADDR_CFG, 32'h02);
      wb(1, ADDR_CAUSE, 32'h3f);
      por_i <= (k == 0);
      bad_opcode_i <= (k == 1 || k == 4);
      stop_exec_i <= (k == 2);
      opcode_fetch_i <= (k == 3 || k == 4);
      unmapped_i <= (k == 3 || k == 4 || k == 6);
      low_voltage_i <= (k == 5);
      @(posedge clk_i);
      {por_i, bad_opcode_i, stop_exec_i, opcode_fetch_i, unmapped_i, low_voltage_i} <= 6'h00;
      n = 0;
      while (internal_reset_o !== 1'b1 && n < 4) begin
         @(posedge clk_i);
         n++;
      end
      if (k == 0 || k == 5) check(cpu_clk_en_o, 0);
      settle;
      check(n, lens[k]);
      wb(0, ADDR_CAUSE, 0);
      check(rd, causes[k]);
      $display("reset kind %0d done", k);
   endtask
   task automatic t_pin;
      wb(1, ADDR_CFG, 32'h00);
      ext_low <= 1;
      repeat (3) @(posedge clk_i);
      check(gpio_in_o, 0);
      check(internal_reset_o, 0);
      ext_low <= 0;
      @(posedge clk_i);
      check(gpio_in_o, 1);
      wb(1, ADDR_CFG, 32'h02);
      wb(1, ADDR_CAUSE, 32'h3f);
      ext_low <= 1;
      repeat (30) @(posedge clk_i);
      check(internal_reset_o, 1);
      ext_low <= 0;
      @(posedge clk_i);
      settle;
      wb(0, ADDR_CAUSE, 0);
      check(rd, 32'h02);
      $display("pin reset done");
   endtask
   task automatic t_wait_service;
      wait_exec_i <= 1;
      @(posedge clk_i);
      wait_exec_i <= 0;
      repeat (2) @(posedge clk_i);
      check({cpu_clk_en_o, periph_clk_en_o}, 2'b01);
      wake_i <= 1;
      @(posedge clk_i);
      wake_i <= 0;
      repeat (2) @(posedge clk_i);
      check(cpu_clk_en_o, 1);
      n = 0;
      while (watchdog_tick_o !== 1'b1 && n < 5000) begin
         @(posedge clk_i);
         n++;
      end
      check(watchdog_tick_o, 1);
      repeat (300) @(posedge clk_i);
      cpu_addr_i <= SERVICE_ADDR;
      cpu_write_i <= 1;
      @(posedge clk_i);
      cpu_write_i <= 0;
      wb(0, ADDR_STATUS, 0);
      check(rd[12:0], 32'h0000_000d);
      wb(0, 32'h0000_0010, 0);
      check(rd, 0);
      $display("wait and service done");
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      wb(0, ADDR_CFG, 0);
      check(rd, 32'h14);
      wb(0, ADDR_CAUSE, 0);
      check(rd, 32'h01);
      monitor_mode_i <= 1;
      @(posedge clk_i);
      check({reset_vector_o, osc_enable_o}, {MON_VECTOR, 1'b1});
      monitor_mode_i <= 0;
      settle;
      for (int k = 0; k < 7; k++) run_reset(k);
      t_pin;
      t_wait_service;
      test_done;
   end
   initial begin
      #200000;
      fails++;
      test_done;
   end
endmodule
`default_nettype wire
